// *** inc/ips_consts.svh ***
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH

// =====================================================================
// Source count and source slots, highest priority first
`define IPS_NUM_SRC        12
`define IPS_SRC_W          4
`define IPS_SRC_NMI        4'h0
`define IPS_SRC_TMR0       4'h1
`define IPS_SRC_TMR1       4'h2
`define IPS_SRC_EXT_RISE   4'h3
`define IPS_SRC_EXT_FALL   4'h4
`define IPS_SRC_EVT_A      4'h5
`define IPS_SRC_EVT_B      4'h6
`define IPS_SRC_CNT_FALL   4'h7
`define IPS_SRC_CONV       4'h8
`define IPS_SRC_SER_RX     4'h9
`define IPS_SRC_SER_TX     4'hA
`define IPS_SRC_SOFT       4'hB
`define IPS_UNMASKABLE     12'h801

// =====================================================================
// Vector addresses of the seven levels
`define IPS_VEC_L0         8'h04
`define IPS_VEC_L1         8'h08
`define IPS_VEC_L2         8'h10
`define IPS_VEC_L3         8'h18
`define IPS_VEC_L4         8'h20
`define IPS_VEC_L5         8'h28
`define IPS_VEC_L6         8'h60
`define IPS_RESTART_ADDR   16'h0000

// =====================================================================
// Pin idle levels and timing
`define IPS_IDLE_NMI       1'b1
`define IPS_IDLE_RISE      1'b0
`define IPS_IDLE_FALL      1'b1
`define IPS_IDLE_STOP      1'b1
`define IPS_STAB_TIME_US   52400
`define IPS_CLK_PERIOD_NS  50
`define IPS_TICK_DIV       16
`define IPS_TICK_W         17

`endif

// *** inc/ips_pkg.sv ***
package ips_pkg;

   // =====================================================================
   // Standby sequencer states
   typedef enum logic [5:0] {
      ST_RUN    = 6'h01,
      ST_HALT   = 6'h02,
      ST_STOP_A = 6'h04,
      ST_STAB_A = 6'h08,
      ST_STOP_B = 6'h10,
      ST_STAB_B = 6'h20
   } standby_state_t;

   typedef logic [11:0] src_vec_t;

endpackage

// *** sim/cpu_seq_model.sv ***
`timescale 1ns/100ps

// ====================
// CPU side: takes the shown vector after a set delay
module cpu_seq_model (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        take,
   input  wire logic [3:0]  delay,
   input  wire logic        irq_req,
   input  wire logic [7:0]  irq_vector,
   input  wire logic [3:0]  irq_source,
   output logic             irq_ack,
   output logic [7:0]       last_vec,
   output logic [3:0]       last_src,
   output logic [15:0]      n_taken
);
   logic [3:0] wait_cnt;

   // One-cycle ack, so a request is never taken twice
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_ack  <= 1'b0;
         wait_cnt <= 4'h0;
         last_vec <= 8'h00;
         last_src <= 4'h0;
         n_taken  <= 16'h0000;
      end else if (irq_ack) begin
         irq_ack  <= 1'b0;
         wait_cnt <= 4'h0;
         last_vec <= irq_vector;
         last_src <= irq_source;
         n_taken  <= n_taken + 16'h0001;
      end else if (irq_req && take) begin
         if (wait_cnt >= delay)
            irq_ack <= 1'b1;
         else
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule

// *** sim/ips_checker.sv ***
`timescale 1ns/100ps
`include "ips_consts.svh"

module ips_checker #(
   parameter int STAB_CYCLES = 64,
   parameter int TICK_DIV    = 4
) (
   input wire logic                  clk_sys,
   input wire logic                  rstn,
   input wire logic                  nmi_pin,
   input wire logic                  stop_pin,
   input wire logic                  timer_zero_match_irq,
   input wire logic [11:0]           irq_enable,
   input wire logic                  irq_ack,
   input wire logic                  halt_instr,
   input wire logic                  stop_instr,
   input wire logic                  irq_req,
   input wire logic [7:0]            irq_vector,
   input wire logic [`IPS_SRC_W-1:0] irq_source,
   input wire logic                  cpu_run,
   input wire logic                  halted,
   input wire logic                  osc_enable,
   input wire logic                  restart_pulse,
   input wire logic [15:0]           restart_address,
   input wire logic                  standby_indicator_flag
);
   // ====================
   // Helpers
   localparam logic [7:0] VEC [12] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h18,
                                      8'h18, 8'h20, 8'h20, 8'h28, 8'h28, 8'h60};
   logic [11:0] en_q;
   int          hi_cnt;

   // Enables lag one edge, as the shown request is registered
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         en_q   <= 12'h000;
         hi_cnt <= 0;
      end else begin
         en_q   <= irq_enable;
         hi_cnt <= stop_pin ? hi_cnt + 1 : 0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_pins_idle;
      (nmi_pin && stop_pin) [*6];
   endsequence

   sequence s_halt_cmd;
      cpu_run && halt_instr && !stop_instr && stop_pin;
   endsequence

   // ====================
   // Properties
   chk_vector_map: assert property (irq_req |-> irq_vector == VEC[irq_source])
      else $error("vector does not match source");
   chk_timer_shown: assert property (timer_zero_match_irq && irq_enable[1] && cpu_run && stop_pin
      && !halt_instr && !stop_instr && !irq_req |=> irq_req)
      else $error("enabled timer request not shown");
   chk_mask_hides: assert property (irq_req |-> irq_source inside {4'h0, 4'hB} || en_q[irq_source])
      else $error("masked source shown");
   chk_ack_clears: assert property (irq_req && irq_ack |=> !irq_req || irq_source != $past(irq_source))
      else $error("acknowledged source still shown");
   chk_halt_entry: assert property (s_halt_cmd |=> halted && !cpu_run && osc_enable)
      else $error("halt not entered with clock running");
   chk_stop_entry: assert property (cpu_run && stop_instr && !halt_instr |=> !osc_enable && !cpu_run)
      else $error("stop instruction left oscillator running");
   chk_stop_hold: assert property (s_pins_idle ##0 !osc_enable |=> !osc_enable)
      else $error("stop left without nmi");
   chk_nmi_wake: assert property (!osc_enable && stop_pin && $fell(nmi_pin) |-> ##[2:8] osc_enable)
      else $error("nmi did not restart oscillator");
   chk_restart_time: assert property (restart_pulse |-> hi_cnt >= STAB_CYCLES
      && hi_cnt <= STAB_CYCLES + 10 && restart_address == 16'h0000)
      else $error("restart at wrong time or address");
   chk_flag_wake: assert property (restart_pulse |-> ##[0:1] standby_indicator_flag)
      else $error("standby flag not set on wake");
endmodule

bind interrupt_priority_standby ips_checker #(.STAB_CYCLES(STAB_CYCLES), .TICK_DIV(TICK_DIV))
   i_ips_checker (.clk_sys, .rstn, .nmi_pin, .stop_pin, .timer_zero_match_irq, .irq_enable,
   .irq_ack, .halt_instr, .stop_instr, .irq_req, .irq_vector, .irq_source, .cpu_run, .halted,
   .osc_enable, .restart_pulse, .restart_address, .standby_indicator_flag);

// *** sim/tb.sv ***
`timescale 1ns/100ps

module tb;
   // ====================
   // Signals
   logic        clk_sys, rstn, power_on_rstn, stop_pin, halt_instr, stop_instr;
   logic        standby_flag_clear, irq_ack, take, irq_req, cpu_run, halted, osc_enable;
   logic        restart_pulse, standby_indicator_flag;
   logic [11:0] src, irq_enable;
   logic [16:0] stab_prog;
   logic [7:0]  irq_vector, last_vec;
   logic [3:0]  irq_source, last_src, delay;
   logic [15:0] restart_address, n_taken;
   int          n_fail, checks, n;
   logic [7:0]  exp_vec [12] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h18,
                                 8'h18, 8'h20, 8'h20, 8'h28, 8'h28, 8'h60};

   interrupt_priority_standby #(.STAB_CYCLES(64), .TICK_DIV(4)) i_interrupt_priority_standby (
      .clk_sys, .rstn, .power_on_rstn, .stop_pin, .irq_enable, .irq_ack, .halt_instr,
      .stop_instr, .stab_prog, .standby_flag_clear, .irq_req, .irq_vector, .irq_source,
      .cpu_run, .halted, .osc_enable, .restart_pulse, .restart_address, .standby_indicator_flag,
      .nmi_pin(src[0]), .timer_zero_match_irq(src[1]), .timer_one_match_irq(src[2]),
      .ext_request_rising_pin(src[3]), .ext_request_falling_pin(src[4]),
      .event_counter_match_a_irq(src[5]), .event_counter_match_b_irq(src[6]),
      .counter_input_fall_irq(src[7]), .converter_done_irq(src[8]),
      .serial_receive_irq(src[9]), .serial_transmit_irq(src[10]), .software_trap_instr(src[11]));

   cpu_seq_model i_cpu_seq_model (.clk_sys, .rstn, .take, .delay, .irq_req, .irq_vector,
      .irq_source, .irq_ack, .last_vec, .last_src, .n_taken);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ====================
   // Shared tasks
   task automatic cyc(int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask

   // Slots 0 and 4 idle high; pins held four cycles for the sync
   task automatic fire(logic [11:0] m);
      @(posedge clk_sys);
      src <= m ^ 12'h011;
      @(posedge clk_sys);
      src <= (m & 12'h019) ^ 12'h011;
      repeat (3) @(posedge clk_sys);
      src <= 12'h011;
   endtask

   task automatic wait_take(logic [15:0] goal);
      n = 0;
      while (n_taken < goal && n < 80) begin
         cyc(1);
         n++;
      end
      chk("takes", goal, n_taken);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ====================
   // Scenarios
   task automatic t_levels;
      logic [15:0] base;
      chk("power-up flag", 16'h0, 16'(standby_indicator_flag));
      for (int s = 0; s < 12; s++) begin
         base = n_taken;
         fire(12'h001 << s);
         wait_take(base + 16'h0001);
         chk("vector", 16'(exp_vec[s]), 16'(last_vec));
         chk("source", 16'(s), 16'(last_src));
         cyc(8);
         chk("single take", base + 16'h0001, n_taken);
      end
      $display("levels test done");
   endtask

   task automatic t_priority;
      logic [15:0] base;
      logic [3:0]  ord [5] = '{4'h2, 4'h8, 4'hA, 4'hB, 4'h9};
      base = n_taken;
      @(posedge clk_sys);
      take       <= 1'b0;
      irq_enable <= 12'hDFF;
      fire(12'hF04);
      @(posedge clk_sys);
      delay <= 4'h3;
      take  <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (i == 4) begin
            cyc(10);
            chk("masked held", base + 16'h0004, n_taken);
            @(posedge clk_sys);
            irq_enable <= 12'hFFF;
         end
         wait_take(base + 16'(i + 1));
         chk("order", 16'(ord[i]), 16'(last_src));
      end
      delay <= 4'h0;
      $display("priority test done");
   endtask

   task automatic t_halt;
      logic [15:0] base;
      @(posedge clk_sys);
      irq_enable <= 12'hFFD;
      halt_instr <= 1'b1;
      @(posedge clk_sys);
      halt_instr <= 1'b0;
      cyc(1);
      chk("halted", 16'h1, 16'(halted));
      chk("clock in halt", 16'h1, 16'(osc_enable));
      base = n_taken;
      fire(12'h002);
      cyc(4);
      chk("masked keeps halt", 16'h0, 16'(cpu_run));
      @(posedge clk_sys);
      irq_enable <= 12'hFFF;
      wait_take(base + 16'h0001);
      chk("woken source", 16'h1, 16'(last_src));
      $display("halt test done");
   endtask

   task automatic t_stop_a;
      logic [15:0] base;
      @(posedge clk_sys);
      standby_flag_clear <= 1'b1;
      stop_instr         <= 1'b1;
      @(posedge clk_sys);
      standby_flag_clear <= 1'b0;
      stop_instr         <= 1'b0;
      cyc(1);
      chk("flag cleared", 16'h0, 16'(standby_indicator_flag));
      chk("osc stopped", 16'h0, 16'(osc_enable));
      fire(12'h00A);
      cyc(4);
      chk("stop held", 16'h0, 16'(osc_enable));
      base = n_taken;
      @(posedge clk_sys);
      src[0] <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      chk("stab wait", 16'h1, 16'(n >= 12 && n <= 24));
      chk("wake flag", 16'h1, 16'(standby_indicator_flag));
      @(posedge clk_sys);
      src[0] <= 1'b1;
      wait_take(base + 16'h0001);
      chk("nmi first", 16'h0, 16'(last_src));
      cyc(20);
      $display("stop A test done");
   endtask

   task automatic t_stop_b;
      @(posedge clk_sys);
      stop_pin <= 1'b0;
      standby_flag_clear <= 1'b1;
      @(posedge clk_sys);
      standby_flag_clear <= 1'b0;
      cyc(9);
      chk("osc stopped", 16'h0, 16'(osc_enable));
      chk("flag cleared", 16'h0, 16'(standby_indicator_flag));
      @(posedge clk_sys);
      stop_pin <= 1'b1;
      n = 0;
      while (restart_pulse !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk("restart wait", 16'h1, 16'(n >= 64 && n <= 74));
      chk("restart address", 16'h0000, restart_address);
      chk("wake flag", 16'h1, 16'(standby_indicator_flag));
      $display("stop B test done");
   endtask

   task automatic t_stretch;
      @(posedge clk_sys);
      stop_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      stop_pin <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (100) @(posedge clk_sys);
      rstn <= 1'b1;
      n = 0;
      repeat (100) begin
         cyc(1);
         if (restart_pulse === 1'b1)
            n++;
      end
      chk("restart after reset", 16'h0, 16'(n));
      chk("running", 16'h1, 16'(cpu_run));
      chk("flag kept", 16'h1, 16'(standby_indicator_flag));
      @(posedge clk_sys);
      power_on_rstn <= 1'b0;
      cyc(1);
      chk("power-up flag", 16'h0, 16'(standby_indicator_flag));
      @(posedge clk_sys);
      power_on_rstn <= 1'b1;
      $display("reset stretch test done");
   endtask

   // ====================
   // Main sequence and watchdog
   initial begin
      {n_fail, checks} = '0;
      {rstn, power_on_rstn, halt_instr, stop_instr, standby_flag_clear} = 5'h00;
      {take, stop_pin, delay, src} = {2'b11, 4'h0, 12'h011};
      irq_enable = 12'hFFF;
      stab_prog  = 17'h00003;
      repeat (6) @(posedge clk_sys);
      rstn          <= 1'b1;
      power_on_rstn <= 1'b1;
      cyc(3);
      t_levels;
      t_priority;
      t_halt;
      t_stop_a;
      t_stop_b;
      t_stretch;
      report_and_stop;
   end

   // Run takes about 590 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      n_fail++;
      report_and_stop;
   end
endmodule

// *** src/interrupt_priority_standby.sv ***
`timescale 1ns/100ps
`include "ips_consts.svh"

// How it works
// RULE1: Twelve sources: three pins, nine internal units or instructions.
// RULE2: Seven levels, zero first; NMI at vector 4, software trap at 96.
// RULE3: Level one, vector 8, from either 8-bit timer match.
// RULE4: Level two, vector 16, from either maskable external pin.
// RULE5: Level three, vector 24, from either event counter match.
// RULE6: Level four, vector 32, counter-input falling edge or converter done.
// RULE7: Level five, vector 40, serial receive or serial transmit.
// RULE8: Halt instruction stops execution; clock, peripherals and state keep running.
// RULE9: Halt ends on any unmasked request or on reset.
// RULE10: Stop instruction enters stop A with oscillator halted.
// RULE11: Stop A leaves only on an NMI pin event or reset; the code also moves it to stop B on a low stop pin.
// RULE12: Stop A exit wait is software-programmed via timer 1, max 52.4 ms.
// RULE13: Readable standby flag tells wake-up from fresh power-up.
// RULE14: Outside party drives stop pin low; oscillator halts, RAM kept.
// RULE15: After stop pin rises, wait 52.4 ms then start at address 0.
// RULE16: Outside party may hold reset low to lengthen that wait.
// RULE17: NMI request is taken on the pin's falling edge.
// RULE18: First maskable pin requests on a rising edge.
// RULE19: Second maskable pin requests on a falling edge.
// RULE20: Highest pending enabled level served first; lower ones stay pending.
module interrupt_priority_standby #(
   parameter int STAB_CYCLES = (`IPS_STAB_TIME_US * 1000) / `IPS_CLK_PERIOD_NS,
   parameter int TICK_DIV    = `IPS_TICK_DIV
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rstn,
   input  wire logic                    power_on_rstn,
   input  wire logic                    nmi_pin,
   input  wire logic                    ext_request_rising_pin,
   input  wire logic                    ext_request_falling_pin,
   input  wire logic                    stop_pin,
   input  wire logic                    timer_zero_match_irq,
   input  wire logic                    timer_one_match_irq,
   input  wire logic                    event_counter_match_a_irq,
   input  wire logic                    event_counter_match_b_irq,
   input  wire logic                    counter_input_fall_irq,
   input  wire logic                    converter_done_irq,
   input  wire logic                    serial_receive_irq,
   input  wire logic                    serial_transmit_irq,
   input  wire logic                    software_trap_instr,
   input  wire logic [11:0]             irq_enable,
   input  wire logic                    irq_ack,
   input  wire logic                    halt_instr,
   input  wire logic                    stop_instr,
   input  wire logic [`IPS_TICK_W-1:0]  stab_prog,
   input  wire logic                    standby_flag_clear,
   output logic                         irq_req,
   output logic [7:0]                   irq_vector,
   output logic [`IPS_SRC_W-1:0]        irq_source,
   output logic                         cpu_run,
   output logic                         halted,
   output logic                         osc_enable,
   output logic                         restart_pulse,
   output logic [15:0]                  restart_address,
   output logic                         standby_indicator_flag
);

   localparam int STAB_TICKS = STAB_CYCLES / TICK_DIV;
   localparam logic [`IPS_TICK_W-1:0] STAB_MAX = `IPS_TICK_W'(STAB_TICKS);

   // =====================================================================
   // Helper functions
   function automatic logic [`IPS_SRC_W-1:0] first_set(input ips_pkg::src_vec_t v);
      logic [`IPS_SRC_W-1:0] idx;
      idx = '0;
      for (int i = `IPS_NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = `IPS_SRC_W'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [7:0] vector_of(input logic [`IPS_SRC_W-1:0] idx);
      logic [7:0] vec;
      vec = `IPS_VEC_L6;
      unique case (idx)
         `IPS_SRC_NMI:                    vec = `IPS_VEC_L0; // RULE2
         `IPS_SRC_TMR0, `IPS_SRC_TMR1:    vec = `IPS_VEC_L1; // RULE3
         `IPS_SRC_EXT_RISE,
         `IPS_SRC_EXT_FALL:               vec = `IPS_VEC_L2; // RULE4
         `IPS_SRC_EVT_A, `IPS_SRC_EVT_B:  vec = `IPS_VEC_L3; // RULE5
         `IPS_SRC_CNT_FALL, `IPS_SRC_CONV: vec = `IPS_VEC_L4; // RULE6
         `IPS_SRC_SER_RX, `IPS_SRC_SER_TX: vec = `IPS_VEC_L5; // RULE7
         default:                         vec = `IPS_VEC_L6; // RULE2
      endcase
      return vec;
   endfunction

   // =====================================================================
   // Pin synchronisers and edge detectors
   logic nmi_edge;
   logic rise_edge;
   logic fall_edge;
   logic stop_level;

   pin_edge_sync #(.IDLE(`IPS_IDLE_NMI), .FALL(1'b1)) u_nmi_sync (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .pin        (nmi_pin),
      .level      (),
      .edge_pulse (nmi_edge) // RULE17
   );

   pin_edge_sync #(.IDLE(`IPS_IDLE_RISE), .FALL(1'b0)) u_rise_sync (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .pin        (ext_request_rising_pin),
      .level      (),
      .edge_pulse (rise_edge) // RULE18
   );

   pin_edge_sync #(.IDLE(`IPS_IDLE_FALL), .FALL(1'b1)) u_fall_sync (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .pin        (ext_request_falling_pin),
      .level      (),
      .edge_pulse (fall_edge) // RULE19
   );

   pin_edge_sync #(.IDLE(`IPS_IDLE_STOP), .FALL(1'b1)) u_stop_sync (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .pin        (stop_pin),
      .level      (stop_level),
      .edge_pulse ()
   );

   // =====================================================================
   // Request collection
   ips_pkg::src_vec_t      raw_set;
   ips_pkg::src_vec_t      pending;
   ips_pkg::src_vec_t      served_clr;
   ips_pkg::src_vec_t      next_pending;
   ips_pkg::src_vec_t      next_enabled;
   ips_pkg::src_vec_t      en_eff;
   logic [`IPS_SRC_W-1:0]  next_idx;
   ips_pkg::standby_state_t state;
   ips_pkg::standby_state_t next_state;

   always_comb begin
      raw_set = '0;
      raw_set[`IPS_SRC_NMI]      = nmi_edge; // RULE1
      raw_set[`IPS_SRC_TMR0]     = timer_zero_match_irq;
      raw_set[`IPS_SRC_TMR1]     = timer_one_match_irq;
      raw_set[`IPS_SRC_EXT_RISE] = rise_edge;
      raw_set[`IPS_SRC_EXT_FALL] = fall_edge;
      raw_set[`IPS_SRC_EVT_A]    = event_counter_match_a_irq;
      raw_set[`IPS_SRC_EVT_B]    = event_counter_match_b_irq;
      raw_set[`IPS_SRC_CNT_FALL] = counter_input_fall_irq;
      raw_set[`IPS_SRC_CONV]     = converter_done_irq;
      raw_set[`IPS_SRC_SER_RX]   = serial_receive_irq;
      raw_set[`IPS_SRC_SER_TX]   = serial_transmit_irq;
      raw_set[`IPS_SRC_SOFT]     = software_trap_instr;
   end

   // NMI and software trap cannot be masked
   assign en_eff = irq_enable | `IPS_UNMASKABLE;

   always_comb begin
      served_clr = '0;
      if (irq_req && irq_ack) begin
         served_clr[irq_source] = 1'b1;
      end
      if (restart_pulse) begin
         served_clr = '1;
      end
      // A new event in the clearing cycle is kept
      next_pending = (pending & ~served_clr) | raw_set; // RULE20
      next_enabled = next_pending & en_eff;
      next_idx     = first_set(next_enabled); // RULE20
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pending <= '0;
      end else begin
         pending <= next_pending;
      end
   end

   // =====================================================================
   // Vector to the sequencer; computed from the next pending set so that
   // an acknowledged source never shows twice
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_req    <= 1'b0;
         irq_vector <= `IPS_VEC_L0;
         irq_source <= `IPS_SRC_NMI;
      end else begin
         irq_req    <= (|next_enabled) && (next_state == ips_pkg::ST_RUN);
         irq_vector <= vector_of(next_idx); // RULE2
         irq_source <= next_idx;
      end
   end

   // =====================================================================
   // Standby sequencer
   logic                   stab_start;
   logic                   stab_done;
   logic [`IPS_TICK_W-1:0] stab_load;
   logic [`IPS_TICK_W-1:0] prog_load;

   // Software wait capped at the longest stabilisation
   assign prog_load = (stab_prog > STAB_MAX) ? STAB_MAX : stab_prog; // RULE12

   always_comb begin
      next_state = state;
      unique case (state)
         ips_pkg::ST_RUN: begin
            if (stop_instr) begin
               next_state = ips_pkg::ST_STOP_A; // RULE10
            end else if (halt_instr) begin
               next_state = ips_pkg::ST_HALT; // RULE8
            end
         end
         ips_pkg::ST_HALT: begin
            if (|next_enabled) begin
               next_state = ips_pkg::ST_RUN; // RULE9
            end
         end
         ips_pkg::ST_STOP_A: begin
            if (nmi_edge) begin
               next_state = ips_pkg::ST_STAB_A; // RULE11
            end
         end
         ips_pkg::ST_STAB_A: begin
            if (stab_done) begin
               next_state = ips_pkg::ST_RUN;
            end
         end
         ips_pkg::ST_STOP_B: begin
            if (stop_level) begin
               next_state = ips_pkg::ST_STAB_B; // RULE15
            end
         end
         ips_pkg::ST_STAB_B: begin
            if (stab_done) begin
               next_state = ips_pkg::ST_RUN;
            end
         end
         default: next_state = ips_pkg::ST_RUN;
      endcase
      // A low stop pin wins from any state
      if (!stop_level) begin
         next_state = ips_pkg::ST_STOP_B; // RULE14
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ips_pkg::ST_RUN; // RULE16
      end else begin
         state <= next_state;
      end
   end

   assign stab_start = (next_state != state) &&
                       ((next_state == ips_pkg::ST_STAB_A) ||
                        (next_state == ips_pkg::ST_STAB_B));
   assign stab_load  = (next_state == ips_pkg::ST_STAB_A) ? prog_load : STAB_MAX; // RULE15

   stab_timer #(.TICK_DIV(TICK_DIV), .CNT_W(`IPS_TICK_W)) u_stab (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .start   (stab_start),
      .load    (stab_load),
      .busy    (),
      .done    (stab_done) // RULE12
   );

   // =====================================================================
   // Status outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         restart_pulse   <= 1'b0;
         restart_address <= `IPS_RESTART_ADDR;
      end else begin
         restart_pulse   <= (state == ips_pkg::ST_STAB_B) && stab_done; // RULE15
         restart_address <= `IPS_RESTART_ADDR;
      end
   end

   assign cpu_run    = state[0];
   assign halted     = state[1]; // RULE8
   // Oscillator is modelled as a gate; the sequencer itself keeps the clock
   assign osc_enable = ~(state[2] | state[4]); // RULE10

   // Survives the pin reset so a wake can be told from power-up
   always_ff @(posedge clk_sys or negedge power_on_rstn) begin
      if (!power_on_rstn) begin
         standby_indicator_flag <= 1'b0;
      end else if (stab_done) begin
         standby_indicator_flag <= 1'b1; // RULE13
      end else if (standby_flag_clear) begin
         standby_indicator_flag <= 1'b0;
      end
   end

endmodule

// *** src/pin_edge_sync.sv ***
`timescale 1ns/100ps
`include "ips_consts.svh"

module pin_edge_sync #(
   parameter logic IDLE = 1'b1,
   parameter logic FALL = 1'b1
) (
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic pin,
   output logic      level,
   output logic      edge_pulse
);

   // =====================================================================
   // Two-stage synchroniser, third stage only for edge history
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta <= IDLE;
         sync <= IDLE;
         prev <= IDLE;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level      = sync;
   assign edge_pulse = FALL ? (prev & ~sync) : (~prev & sync);

endmodule

// *** src/stab_timer.sv ***
`timescale 1ns/100ps
`include "ips_consts.svh"

module stab_timer #(
   parameter int TICK_DIV = `IPS_TICK_DIV,
   parameter int CNT_W    = `IPS_TICK_W
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] load,
   output logic                  busy,
   output logic                  done
);

   // =====================================================================
   // Tick divider; restarts with each wait so the first tick is full
   logic [15:0]      div;
   logic             tick;
   logic [CNT_W-1:0] remain;

   assign tick = busy && (div == 16'(TICK_DIV - 1));

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div <= 16'h0000;
      end else if (start || tick) begin
         div <= 16'h0000;
      end else if (busy) begin
         div <= div + 16'h0001;
      end
   end

   // =====================================================================
   // Tick countdown; a zero load still waits one tick
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         remain <= '0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            remain <= load;
            busy   <= 1'b1;
         end else if (tick) begin
            if (remain <= CNT_W'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               remain <= remain - CNT_W'(1);
            end
         end
      end
   end

endmodule
